// File: src/acs_pkg.sv
// constants, register map and carrier types of the conversion sequencer
// assumes one 25 MHz clock shared with the bus, triggers and converter core
package acs_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets, one aligned 32-bit word each; the result windows hold 16 and 4 words)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int NREG = 9;
  localparam logic [ADDR_W-1:0] OFS_DIFFERENTIAL_SELECT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONVERSION_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_TIME_SELECT0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_TIME_SELECT1 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_REGULAR_SEQUENCE_SELECT0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REGULAR_SEQUENCE_SELECT1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_REGULAR_SEQUENCE_SELECT2 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INJECTED_SEQUENCE_REGISTER = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_REGULAR_RESULT = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_INJECTED_RESULT = 8'h80;
  // register indices
  localparam int IX_DIF = 0;
  localparam int IX_CFG = 1;
  localparam int IX_SMP0 = 2;
  localparam int IX_SMP1 = 3;
  localparam int IX_SQR0 = 4;
  localparam int IX_SQR1 = 5;
  localparam int IX_SQR2 = 6;
  localparam int IX_JSQR = 7;
  localparam int IX_IER = 8;
  // writable bits per register, the rest reads as zero
  localparam logic [NREG-1:0][31:0] WR_MASK = {
    32'h0000006c, 32'h0003ffff, 32'h0000000f, 32'hffffffff,
    32'hffffffff, 32'h000001ff, 32'h3fffffff, 32'h021f2018,
    32'h00003ffe};
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POS_AUTO_INJECTION = 25;
  localparam int POS_INJ_DISC = 20;
  localparam int POS_DISC_COUNT = 17;
  localparam int POS_REG_DISC = 16;
  localparam int POS_CONTINUOUS_CONVERSION_BIT = 13;
  localparam int POS_RES = 3;
  localparam int POS_EOC_IE = 2;
  localparam int POS_EOS_IE = 3;
  localparam int POS_JEOC_IE = 5;
  localparam int POS_JEOS_IE = 6;
  localparam int POS_JL = 0;
  localparam int POS_JSLOT = 2;
  localparam int SMP_PER_REG0 = 10;
  localparam int CH_W = 4;
  localparam int RES_W = 12;

  // ----------------------------------------------------------------------
  // timing, in half converter clock cycles as printed (x2)
  // ----------------------------------------------------------------------
  localparam logic [10:0] SMP_HALF [8] = '{11'h003, 11'h005, 11'h009,
    11'h00f, 11'h027, 11'h07b, 11'h16b, 11'h4b3};
  localparam logic [10:0] CONV_HALF [4] = '{11'h019, 11'h015, 11'h011,
    11'h00d};
  localparam int CNT_W = 10;

  // ----------------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } acs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acs_axi_rsp_t;

  typedef struct packed {
    logic start;              // one-cycle pulse, sampling begins
    logic [CH_W-1:0] channel; // positive input
    logic [CH_W-1:0] negative_channel;
    logic differential;
    logic [1:0] resolution;
  } acs_conv_t;

  typedef struct packed {
    logic eoc;
    logic eos;
    logic jeoc;
    logic jeos;
  } acs_flags_t;

  typedef enum logic {PH_IDLE, PH_CONV} acs_phase_t;

endpackage : acs_pkg

// File: src/acs_sequencer.sv
// regular and injected conversion sequencer with an AXI4-Lite slave
// assumes triggers, converter data and bus all run on aclk
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module acs_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire acs_pkg::acs_axi_req_t axi_req,
  output acs_pkg::acs_axi_rsp_t axi_rsp,
  input wire logic regular_trigger_in,
  input wire logic injected_trigger_in,
  input wire logic [acs_pkg::RES_W-1:0] conv_data,
  output acs_pkg::acs_conv_t conv_ctrl,
  output acs_pkg::acs_flags_t flags,
  output logic conversion_active,
  output logic [15:0][acs_pkg::RES_W-1:0] regular_result_vector,
  output logic [3:0][acs_pkg::RES_W-1:0] injected_result_vector,
  output logic [3:0] regular_result_last,
  output logic [1:0] injected_result_last
);
  import acs_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NREG-1:0][31:0] regs;         // software registers
    acs_axi_rsp_t rsp;                   // bus answer flops
    acs_phase_t phase;                   // idle or converting
    logic inj;                           // current group is injected
    logic [3:0] idx_reg;                 // next regular slot
    logic [1:0] idx_inj;                 // next injected slot
    logic [2:0] disc_left;               // burst conversions remaining
    logic [CNT_W-1:0] cnt;               // cycles left in conversion
    acs_conv_t conv;                     // to converter core
    acs_flags_t flags;                   // event pulses
    logic busy;                          // activity
    // sixteen regular and four injected result slots
    logic [15:0][RES_W-1:0] rres;
    logic [3:0][RES_W-1:0] jres;
  } acs_state_t;

  acs_state_t q;
  acs_state_t d;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // channel selected by a slot of either group
  function automatic logic [CH_W-1:0] slot_chan(
    input logic [NREG-1:0][31:0] r,
    input logic inj,
    input logic [3:0] idx
  );
    logic [CH_W-1:0] ch;
    ch = '0;
    // slots 1-8 sit in the first word, 9-16 in the second
    if (inj) begin
      ch = r[IX_JSQR][POS_JSLOT + 4 * idx[1:0] +: CH_W];
    end else if (!idx[3]) begin
      ch = r[IX_SQR0][4 * idx[2:0] +: CH_W];
    end else begin
      ch = r[IX_SQR1][4 * idx[2:0] +: CH_W];
    end
    return ch;
  endfunction : slot_chan

  // whole cycles of sample plus conversion for a channel
  function automatic logic [CNT_W-1:0] conv_cycles(
    input logic [NREG-1:0][31:0] r,
    input logic [CH_W-1:0] ch
  );
    logic [2:0] code;
    logic [10:0] half;
    code = '0;
    half = '0;
    // channel 0 or above 13 is a software fault: code 0 keeps the
    // count defined instead of reading outside the word
    if (ch == '0 || ch > 4'hd) begin
      code = '0;
    end else if (ch <= CH_W'(SMP_PER_REG0)) begin
      code = r[IX_SMP0][3 * (ch - CH_W'(1)) +: 3];
    end else begin
      code = r[IX_SMP1][3 * (ch - CH_W'(SMP_PER_REG0 + 1)) +: 3];
    end
    // both halves end in .5, so the sum is whole
    half = SMP_HALF[code] + CONV_HALF[r[IX_CFG][POS_RES +: 2]];
    return half[CNT_W:1];
  endfunction : conv_cycles

  // register index of a byte address, valid flag in the top bit
  // status and result windows are decoded in the read path
  function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [4:0] r;
    r = '0;
    if (a[1:0] == 2'h0 && a < OFS_STATUS) begin
      r = {1'b1, a[5:2]};
    end
    return r;
  endfunction : reg_index

  // apply byte strobes
  // bits outside the writable mask always read back as zero
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] st,
    input logic [31:0] mask
  );
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[8 * b +: 8] = old[8 * b +: 8];
      if (st[b]) begin
        m[8 * b +: 8] = wd[8 * b +: 8];
      end
    end
    return m & mask;
  endfunction : merge

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] wix;
    logic [4:0] rix;
    logic [31:0] rd;
    logic rd_ok;
    logic launch;
    logic launch_inj;
    logic [3:0] launch_idx;
    logic [CH_W-1:0] ch;
    logic last;
    logic [3:0] len_reg;
    logic [1:0] len_inj;
    wix = '0;
    rix = '0;
    rd = '0;
    rd_ok = 1'b0;
    launch = 1'b0;
    launch_inj = 1'b0;
    launch_idx = '0;
    ch = '0;
    last = 1'b0;
    // lengths are kept as the index of the last slot
    len_reg = q.regs[IX_SQR2][3:0];
    len_inj = q.regs[IX_JSQR][POS_JL +: 2];
    d = q;
    // start and flags are single-cycle pulses
    d.conv.start = 1'b0;
    d.flags = '0;

    // bus write: take address and data together, answer next cycle
    // a pending bvalid holds off the next write until it is taken
    if (q.rsp.awready) begin
      d.rsp.awready = 1'b0;
      d.rsp.wready = 1'b0;
      d.rsp.bvalid = 1'b1;
      wix = reg_index(axi_req.awaddr);
      if (wix[4] && wix[3:0] < 4'(NREG)) begin
        d.regs[wix[3:0]] = merge(q.regs[wix[3:0]], axi_req.wdata,
          axi_req.wstrb, WR_MASK[wix[3:0]]);
        d.rsp.bresp = RESP_OKAY;
      end else begin
        d.rsp.bresp = RESP_SLVERR; // unmapped or read-only
      end
    end else if (!q.rsp.bvalid && axi_req.awvalid && axi_req.wvalid) begin
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end

    // bus read
    // read data is captured in the arready cycle and held
    if (q.rsp.arready) begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      rix = reg_index(axi_req.araddr);
      if (rix[4] && rix[3:0] < 4'(NREG)) begin
        rd = q.regs[rix[3:0]];
        rd_ok = 1'b1;
      end else if (axi_req.araddr == OFS_STATUS) begin
        // busy, group, slot pointers
        rd = {24'h000000, q.busy, q.inj, q.idx_inj, q.idx_reg};
        rd_ok = 1'b1;
      end else if (axi_req.araddr[1:0] == 2'h0 &&
                   axi_req.araddr[7:6] == OFS_REGULAR_RESULT[7:6]) begin
        rd = 32'(q.rres[axi_req.araddr[5:2]]);
        rd_ok = 1'b1;
      end else if (axi_req.araddr[1:0] == 2'h0 &&
                   axi_req.araddr[7:4] == OFS_INJECTED_RESULT[7:4]) begin
        rd = 32'(q.jres[axi_req.araddr[3:2]]);
        rd_ok = 1'b1;
      end
      d.rsp.rdata = rd;
      d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (!q.rsp.rvalid && axi_req.arvalid) begin
      d.rsp.arready = 1'b1;
    end
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end

    // sequencer
    case (q.phase)
      PH_IDLE: begin
        // triggers only seen here, so busy ignores them
        if (injected_trigger_in) begin
          launch = 1'b1;
          launch_inj = 1'b1;
          launch_idx = {2'h0, q.idx_inj};
        end else if (regular_trigger_in) begin
          launch = 1'b1;
          launch_idx = q.idx_reg;
          d.disc_left = q.regs[IX_CFG][POS_DISC_COUNT +: 3];
        end
      end
      PH_CONV: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - CNT_W'(1);
        end else if (!q.inj) begin
          // regular element done
          // converter data is taken on the last counted cycle
          d.rres[q.idx_reg] = conv_data;
          d.flags.eoc = q.regs[IX_IER][POS_EOC_IE];
          last = (q.idx_reg == len_reg);
          if (last) begin
            d.flags.eos = q.regs[IX_IER][POS_EOS_IE];
            d.idx_reg = '0;
            if (q.regs[IX_CFG][POS_AUTO_INJECTION]) begin
              launch = 1'b1;
              launch_inj = 1'b1;
              launch_idx = {2'h0, q.idx_inj};
            end
          end else begin
            d.idx_reg = q.idx_reg + 4'h1;
            if (!q.regs[IX_CFG][POS_REG_DISC]) begin
              launch = 1'b1;
              launch_idx = q.idx_reg + 4'h1;
            end else if (q.disc_left != '0) begin
              d.disc_left = q.disc_left - 3'h1;
              launch = 1'b1;
              launch_idx = q.idx_reg + 4'h1;
            end
          end
        end else begin
          // injected element done
          d.jres[q.idx_inj] = conv_data;
          d.flags.jeoc = q.regs[IX_IER][POS_JEOC_IE];
          last = (q.idx_inj == len_inj);
          if (last) begin
            d.flags.jeos = q.regs[IX_IER][POS_JEOS_IE];
            d.idx_inj = '0;
          end else begin
            d.idx_inj = q.idx_inj + 2'h1;
            if (!q.regs[IX_CFG][POS_INJ_DISC]) begin
              launch = 1'b1;
              launch_inj = 1'b1;
              launch_idx = {2'h0, q.idx_inj + 2'h1};
            end
          end
        end
        // nothing chained on: drop to idle and wait for a trigger
        if (q.cnt == '0 && !launch) begin
          d.phase = PH_IDLE;
          d.busy = 1'b0;
        end
      end
      default: begin
        d.phase = PH_IDLE;
        d.busy = 1'b0;
      end
    endcase

    // start one element of the chosen group
    if (launch) begin
      ch = slot_chan(q.regs, launch_inj, launch_idx);
      d.phase = PH_CONV;
      d.busy = 1'b1;
      d.inj = launch_inj;
      d.conv.start = 1'b1;
      d.conv.channel = ch;
      d.conv.differential = q.regs[IX_DIF][ch];
      d.conv.negative_channel = ch + CH_W'(1);
      d.conv.resolution = q.regs[IX_CFG][POS_RES +: 2];
      d.cnt = conv_cycles(q.regs, ch) - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // every field clears; registers take their reset word
      q <= '0;
      q.regs <= {NREG{REG_RESET}};
      q.phase <= PH_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  assign axi_rsp = q.rsp;
  assign conv_ctrl = q.conv;
  assign flags = q.flags;
  assign conversion_active = q.busy;
  assign regular_result_vector = q.rres;
  assign injected_result_vector = q.jres;
  // last-index outputs come straight from the length fields
  assign regular_result_last = q.regs[IX_SQR2][3:0];
  assign injected_result_last = q.regs[IX_JSQR][POS_JL +: 2];

endmodule : acs_sequencer

// File: bench/acs_sequencer_sva.sv
// checker of the conversion sequencer ports
// assumes one clock, aresetn synchronous active low
`timescale 1ns/1ps

module acs_sequencer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire acs_pkg::acs_axi_req_t axi_req,
  input wire acs_pkg::acs_axi_rsp_t axi_rsp,
  input wire logic regular_trigger_in,
  input wire logic injected_trigger_in,
  input wire acs_pkg::acs_conv_t conv_ctrl,
  input wire acs_pkg::acs_flags_t flags,
  input wire logic conversion_active
);
  import acs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------
  // conversion control
  // ------
  chk_trig_taken: assert property (!conversion_active &&
    (regular_trigger_in || injected_trigger_in) |=>
    conv_ctrl.start && conversion_active) else $error("idle trigger lost");
  chk_min_element: assert property (conv_ctrl.start |=>
    !conv_ctrl.start [*7]) else $error("element too short");
  chk_busy_run: assert property (conv_ctrl.start |->
    conversion_active [*8]) else $error("activity dropped early");
  chk_rise_start: assert property ($rose(conversion_active) |->
    conv_ctrl.start) else $error("activity without start");
  chk_neg_input: assert property (conv_ctrl.start |->
    conv_ctrl.negative_channel == conv_ctrl.channel + 4'h1)
    else $error("negative input not next channel");
  chk_done_pulse: assert property (flags.eoc || flags.jeoc |=>
    !(flags.eoc || flags.jeoc)) else $error("done flag not a pulse");
  chk_done_busy: assert property (flags.eoc || flags.jeoc |->
    $past(conversion_active)) else $error("done flag while idle");

  // ------
  // register bus answers
  // ------
  chk_write_resp: assert property (axi_rsp.awready |=> axi_rsp.bvalid)
    else $error("write response late");
  chk_read_resp: assert property (axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");

  // main scenarios reached
  cov_eos: cover property (flags.eos);
  cov_jeos: cover property (flags.jeos);
  cov_busy_trig: cover property (conversion_active && regular_trigger_in);
endmodule : acs_sequencer_sva

// File: bench/acs_conv_model.sv
// behavioural converter core facing the sequencer
// assumes the result is sampled on the last active cycle
`timescale 1ns/1ps

module acs_conv_model (
  input wire logic aclk,
  input wire acs_pkg::acs_conv_t conv_ctrl,
  input wire logic conversion_active,
  output logic [acs_pkg::RES_W-1:0] conv_data
);
  import acs_pkg::*;
  logic [RES_W-1:0] idle_q = 12'h000; // churns so idle data does not stay at one value

  // idle pattern changes every cycle
  always @(posedge aclk) begin
    idle_q <= idle_q + 12'h3b7;
  end

  // result encodes mode, positive and negative input
  assign conv_data = conversion_active ? {3'h5, conv_ctrl.differential,
    conv_ctrl.channel, conv_ctrl.negative_channel} : idle_q;
endmodule : acs_conv_model

// File: bench/tb_acs_sequencer.sv
// self-checking testbench of the conversion sequencer
// assumes the checker and converter model are compiled first
`timescale 1ns/1ps

module tb_acs_sequencer;
  import acs_pkg::*;
  typedef struct packed {
    logic [3:0] l;
    logic [31:0] s0;
    logic [31:0] s1;
    logic [31:0] dif;
  } acs_row_t;
  logic aclk, aresetn, rt, it, act;
  acs_axi_req_t rq;
  acs_axi_rsp_t rsp;
  logic [RES_W-1:0] cd;
  acs_conv_t cc;
  acs_flags_t fl;
  logic [15:0][RES_W-1:0] rvec;
  logic [3:0][RES_W-1:0] jvec;
  logic [3:0] rlast;
  logic [1:0] jlast;
  logic [31:0] d, dv;
  logic [63:0] sq;
  logic [1:0] r;
  int mismatches, total_checks, cyc, t0, len, n_eoc, n_eos, n_jeoc, n_jeos;
  int e0, s0;
  int sh[8] = '{3, 5, 9, 15, 39, 123, 363, 1203}; // sample, half cycles
  int cv[4] = '{25, 21, 17, 13}; // conversion, half cycles
  logic [3:0] jch[4] = '{4'h2, 4'h4, 4'h6, 4'h9};
  acs_row_t rows[3] = '{'{4'h0, 32'h5, 32'h0, 32'h0},
    '{4'hf, 32'h87654321, 32'h3219dcba, 32'h0},
    '{4'h2, 32'h713, 32'h0, 32'h88}};

  acs_sequencer acs_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
    .axi_req(rq), .axi_rsp(rsp), .regular_trigger_in(rt),
    .injected_trigger_in(it), .conv_data(cd), .conv_ctrl(cc), .flags(fl),
    .conversion_active(act), .regular_result_vector(rvec),
    .injected_result_vector(jvec), .regular_result_last(rlast),
    .injected_result_last(jlast));
  acs_conv_model acs_conv_model_inst (.aclk(aclk), .conv_ctrl(cc),
    .conversion_active(act), .conv_data(cd));

  // ------
  // clock and event counters
  // ------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cc.start) t0 <= cyc;
    if (fl.eoc || fl.jeoc) len <= cyc - t0;
    n_eoc <= n_eoc + int'(fl.eoc);
    n_eos <= n_eos + int'(fl.eos);
    n_jeoc <= n_jeoc + int'(fl.jeoc);
    n_jeos <= n_jeos + int'(fl.jeos);
  end

  // ------
  // compare, bus and trigger tasks
  // ------
  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_cnt(input string n, input int e, input int g);
    total_checks++;
    if (g != e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_cnt
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) rq.awvalid <= 1'b0;
      if (rsp.wready) rq.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rs = rsp.bresp;
    rq.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) rq.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    v = rsp.rdata;
    rs = rsp.rresp;
    rq.rready <= 1'b0;
  endtask : rd
  // one-cycle trigger pulse
  task automatic trig(input bit inj);
    @(posedge aclk);
    if (inj) it <= 1'b1;
    else rt <= 1'b1;
    @(posedge aclk);
    it <= 1'b0;
    rt <= 1'b0;
  endtask : trig
  // wait for the run to end, then let counters land
  task automatic idle();
    do @(posedge aclk); while (act);
    @(posedge aclk);
  endtask : idle
  // triggers until tot elements done, per elements each
  task automatic go(input bit inj, input int per, input int tot);
    int rem, a0, b0, x;
    rem = tot;
    while (rem > 0) begin
      a0 = inj ? n_jeoc : n_eoc;
      b0 = inj ? n_jeos : n_eos;
      trig(inj);
      idle();
      x = (per < rem) ? per : rem;
      rem -= x;
      chk_cnt("elements", x, (inj ? n_jeoc : n_eoc) - a0);
      chk_cnt("ends", int'(rem == 0), (inj ? n_jeos : n_eos) - b0);
    end
  endtask : go
  function automatic logic [31:0] ex(input logic [3:0] ch);
    return {20'h0, 3'h5, dv[ch], ch, ch + 4'h1};
  endfunction : ex
  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ------
  // main sequence
  // ------
  initial begin
    rq = '0;
    rt = 1'b0;
    it = 1'b0;
    aresetn = 1'b0;
    dv = 32'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NREG; i++) begin
      rd(8'(4 * i), d, r);
      chk_reg("reset value", REG_RESET, d);
    end
    rd(8'h3c, d, r);
    chk_reg("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk_reg("unmapped data", 32'h0, d);
    wr(OFS_STATUS, 32'hffffffff, r);
    chk_reg("status write resp", 32'(RESP_SLVERR), 32'(r));
    wr(OFS_DIFFERENTIAL_SELECT, 32'hffffffff, r);
    rd(OFS_DIFFERENTIAL_SELECT, d, r);
    chk_reg("select bits", 32'h3ffe, d);
    wr(OFS_INTERRUPT_ENABLE, 32'h6c, r);
    foreach (rows[i]) begin
      dv = rows[i].dif;
      sq = {rows[i].s1, rows[i].s0};
      wr(OFS_DIFFERENTIAL_SELECT, dv, r);
      wr(OFS_REGULAR_SEQUENCE_SELECT0, rows[i].s0, r);
      wr(OFS_REGULAR_SEQUENCE_SELECT1, rows[i].s1, r);
      wr(OFS_REGULAR_SEQUENCE_SELECT2, {28'h0, rows[i].l}, r);
      repeat (2) go(1'b0, 16, int'(rows[i].l) + 1);
      chk_reg("length", {28'h0, rows[i].l}, {28'h0, rlast});
      for (int k = 0; k <= int'(rows[i].l); k++)
        chk_reg("result", ex(sq[4*k+:4]), {20'h0, rvec[k]});
    end
    wr(OFS_REGULAR_SEQUENCE_SELECT0, 32'h1, r);
    wr(OFS_REGULAR_SEQUENCE_SELECT2, 32'h0, r);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_SAMPLE_TIME_SELECT0, 32'(c), r);
      wr(OFS_CONVERSION_CONFIG, 32'(c % 4) << 3, r);
      go(1'b0, 1, 1);
      chk_cnt("cycles", (sh[c] + cv[c % 4]) / 2, len);
      chk_reg("resolution", 32'(c % 4), 32'(cc.resolution));
    end
    wr(OFS_SAMPLE_TIME_SELECT0, 32'h0, r);
    wr(OFS_REGULAR_SEQUENCE_SELECT0, 32'h87654321, r);
    wr(OFS_REGULAR_SEQUENCE_SELECT1, 32'h000000ba, r);
    wr(OFS_REGULAR_SEQUENCE_SELECT2, 32'h9, r);
    for (int k = 0; k < 8; k += 7) begin
      wr(OFS_CONVERSION_CONFIG, 32'h10000 | (32'(k) << 17), r);
      go(1'b0, k + 1, 10);
    end
    wr(OFS_INJECTED_SEQUENCE_REGISTER, 32'h2590b, r);
    wr(OFS_CONVERSION_CONFIG, 32'h0, r);
    go(1'b1, 4, 4);
    chk_reg("inj length", 32'h3, {30'h0, jlast});
    for (int k = 0; k < 4; k++)
      chk_reg("inj result", ex(jch[k]), {20'h0, jvec[k]});
    wr(OFS_CONVERSION_CONFIG, 32'h100000, r);
    go(1'b1, 1, 4);
    wr(OFS_CONVERSION_CONFIG, 32'h2000000, r);
    wr(OFS_REGULAR_SEQUENCE_SELECT2, 32'h0, r);
    e0 = n_jeos;
    trig(1'b0);
    idle();
    chk_cnt("auto start", 1, n_jeos - e0);
    wr(OFS_CONVERSION_CONFIG, 32'h0, r);
    e0 = n_eoc;
    s0 = n_jeos;
    trig(1'b0);
    repeat (3) @(posedge aclk);
    rd(OFS_STATUS, d, r);
    chk_reg("status busy", 32'h80, d);
    trig(1'b1);
    trig(1'b0);
    idle();
    chk_cnt("busy triggers", 1, n_eoc - e0);
    chk_cnt("no auto start", 0, n_jeos - s0);
    wr(OFS_INTERRUPT_ENABLE, 32'h0, r);
    e0 = n_eoc;
    s0 = n_eos;
    trig(1'b0);
    idle();
    chk_cnt("masked flags", 0, n_eoc - e0 + n_eos - s0);
    trig(1'b0);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_reg("active after reset", 32'h0, {31'h0, act});
    chk_reg("result after reset", 32'h0, {20'h0, rvec[0]});
    close_out();
  end

  // hang guard
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    close_out();
  end
endmodule : tb_acs_sequencer

bind acs_sequencer acs_sequencer_sva acs_sequencer_sva_inst (.aclk(aclk),
  .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .regular_trigger_in(regular_trigger_in),
  .injected_trigger_in(injected_trigger_in), .conv_ctrl(conv_ctrl),
  .flags(flags), .conversion_active(conversion_active));
